//--- strap_loader_map.vh
`ifndef STRAP_LOADER_MAP_VH
`define STRAP_LOADER_MAP_VH
// How it works
// - hard mode: six two-state pins latched after reset pick one of 64 pages
// - hard mode: serial interface stays enabled, address low bits forced to zero
// - hard mode: divider sync pulse after power-up and after each power-down cycle
// - invalid channel source mutes channel; defaults mute enable 1, level 3
// - muted differential output at mute level 3: positive node to rail, negative node to ground
// - muted single-ended output forced low at mute level 3
// - each channel has 8-bit divide field giving ratios 1 to 256
// - status pins are status or clock; clock use has divider and edge rate
// - soft mode: two three-state pins give 9 codes: 6 pages, defaults, 2 invalid
// - both page pins floating in soft mode loads hardware register defaults
// - soft mode: pin 0 is an active-low output sync input
// - soft mode: three-state pin sets address low bits to 0, 1 or 3
// - soft mode: pin 4 enables margining, pin 5 selects margin offset
// - every stored page carries an 8-bit page identifier
// - register file is 124 eight-bit registers numbered from zero
// - feedback divider: 12-bit integer 1..4095, 22-bit numerator and denominator
// - reference divider 1..8 (1 for secondary), input divider 1..32, doubler 1 or 2
// - output rate is reference on bypass, else vco over post times output divide
// - post divider only takes values 2 through 7
// - outputs stay disabled during reset and initialisation

// register file size
`define REG_COUNT      7'd124
`define REG_LAST       7'd123
// register offsets
`define OFS_PAGE_ID    7'h00
`define OFS_CH_DIV     7'h01
`define OFS_CH_CFG     7'h09
`define OFS_STATUS_CFG 7'h11
`define OFS_STATUS_DIV 7'h12
`define OFS_PLL_BASE   7'h14
`define OFS_PLL_END    7'h28
`define PLL_STRIDE     7'h0A
`define PLL_INT_LO     7'h00
`define PLL_INT_HI     7'h01
`define PLL_NUM        7'h02
`define PLL_DEN        7'h05
`define PLL_REFCFG     7'h08
`define PLL_DIVCFG     7'h09
// field positions
`define CFG_MUX_LSB    0
`define CFG_MUTE_EN    2
`define CFG_MUTE_LSB   3
`define CFG_CMOS       5
`define ST_MODE_LSB    0
`define ST_SLEW_LSB    2
`define REF_DIV_LSB    0
`define REF_DOUBLER    3
`define REF_SECONDARY  4
`define IN_DIV_LSB     0
`define POST_LSB       5
// default register values and mute drive level
`define DEF_ZERO       8'h00
`define DEF_CH_DIV     8'h03
`define DEF_CH_CFG     8'h1C
`define DEF_INT_LO     8'h64
`define DEF_DEN_LO     8'h01
`define DEF_DIVCFG     8'h40
`define MUTE_LVL_DRIVE 2'h3
// pin codes
`define TRI_GND        2'h0
`define TRI_MID        2'h1
`define TRI_SUP        2'h2
`define TRI_FLOAT      2'h3
`define ADDR_GND       2'h0
`define ADDR_MID       2'h1
`define ADDR_SUP       2'h3
`define HARD_ADDR_LSB  2'h0
`define EEPROM_BASE    7'h40
`define SEL_DEFAULTS   3'h6
`define SEL_INVALID    3'h7
`endif

//--- pin_strap_config_page_loader.v
`timescale 1ns/100ps
`include "strap_loader_map.vh"
module pin_strap_config_page_loader (
  // clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // straps and pins
  input  wire        config_source_select,
  input  wire        powerdown_pin,
  input  wire [5:0]  gpio_level,
  input  wire [1:0]  gpio1_state,
  input  wire [1:0]  gpio2_state,
  input  wire [1:0]  gpio3_state,
  input  wire [2:0]  gpio5_level,
  // source health
  input  wire [1:0]  pll_locked,
  input  wire [1:0]  ref_present,
  // page storage read port
  output reg  [6:0]  store_page,
  output reg  [6:0]  store_addr,
  output reg         store_read,
  input  wire [7:0]  store_data,
  // serial host register port
  input  wire        reg_wr_en,
  input  wire [6:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  output reg         serial_enable,
  output reg  [1:0]  serial_addr_lsb,
  // configuration state
  output reg         hard_mode,
  output reg         config_invalid,
  output reg         init_busy,
  output reg  [7:0]  page_id,
  // sync and margining
  output reg         divider_sync,
  output reg         margin_enable,
  output reg  [2:0]  margin_offset,
  // channel outputs
  output reg  [7:0]  out_enable,
  output reg  [7:0]  pos_node_high,
  output reg  [7:0]  neg_node_low,
  output reg  [7:0]  cmos_force_low,
  output reg  [7:0]  chan_bypass,
  output reg  [87:0] chan_total_divide,
  // status pins
  output reg  [1:0]  status_clock_mode,
  output reg  [15:0] status_divide,
  output reg  [3:0]  status_slew,
  // synthesizer fields
  output reg  [23:0] pll_int,
  output reg  [43:0] pll_num,
  output reg  [43:0] pll_den,
  output reg  [7:0]  pll_ref_div,
  output reg  [11:0] pll_in_div,
  output reg  [3:0]  pll_doubler,
  output reg  [7:0]  pll_post
);

  localparam ST_DOWN    = 5'h01;
  localparam ST_LATCH   = 5'h02;
  localparam ST_FETCH   = 5'h04;
  localparam ST_DEFAULT = 5'h08;
  localparam ST_RUN     = 5'h10;

  // ==========================================================
  // functions
  function [1:0] tri_norm;
    input [1:0] s;
    // floating pin reads as mid level
    tri_norm = (s == `TRI_FLOAT) ? `TRI_MID : s;
  endfunction

  function [2:0] soft_select;
    input [1:0] hi;
    input [1:0] lo;
    begin
      case ({tri_norm(hi), tri_norm(lo)})
        {`TRI_GND, `TRI_GND}: soft_select = 3'h0;
        {`TRI_GND, `TRI_MID}: soft_select = 3'h1;
        {`TRI_GND, `TRI_SUP}: soft_select = 3'h2;
        {`TRI_MID, `TRI_GND}: soft_select = 3'h3;
        {`TRI_MID, `TRI_MID}: soft_select = `SEL_DEFAULTS;
        {`TRI_SUP, `TRI_GND}: soft_select = 3'h4;
        {`TRI_SUP, `TRI_SUP}: soft_select = 3'h5;
        default:              soft_select = `SEL_INVALID;
      endcase
    end
  endfunction

  function [1:0] addr_lsb;
    input [1:0] s;
    begin
      case (tri_norm(s))
        `TRI_GND: addr_lsb = `ADDR_GND;
        `TRI_MID: addr_lsb = `ADDR_MID;
        default:  addr_lsb = `ADDR_SUP;
      endcase
    end
  endfunction

  function [3:0] post_ratio;
    input [2:0] f;
    post_ratio = (f < 3'h2) ? 4'h2 : {1'b0, f};
  endfunction

  function [10:0] total_divide;
    input [3:0] post;
    input [7:0] div;
    // divide field plus one times post divider
    total_divide = {7'h00, post} * ({3'h0, div} + 11'h001);
  endfunction

  function [7:0] default_value;
    input [6:0] a;
    reg [6:0] rel;
    begin
      rel = (a >= `OFS_PLL_BASE + `PLL_STRIDE) ? a - `OFS_PLL_BASE - `PLL_STRIDE : a - `OFS_PLL_BASE;
      if (a >= `OFS_CH_DIV && a < `OFS_CH_CFG)
        default_value = `DEF_CH_DIV;
      else if (a >= `OFS_CH_CFG && a < `OFS_STATUS_CFG)
        default_value = `DEF_CH_CFG;
      else if (a >= `OFS_PLL_BASE && a < `OFS_PLL_END && rel == `PLL_INT_LO)
        default_value = `DEF_INT_LO;
      else if (a >= `OFS_PLL_BASE && a < `OFS_PLL_END && rel == `PLL_DEN)
        default_value = `DEF_DEN_LO;
      else if (a >= `OFS_PLL_BASE && a < `OFS_PLL_END && rel == `PLL_DIVCFG)
        default_value = `DEF_DIVCFG;
      else
        default_value = `DEF_ZERO;
    end
  endfunction

  // ==========================================================
  // state
  // 124 eight-bit registers
  reg [7:0] regs_reg [0:123];
  reg [4:0] state_reg;
  integer   k;
  wire [2:0] soft_sel        = soft_select(gpio3_state, gpio2_state);
  wire       output_sync_low = gpio_level[0];

  // ==========================================================
  // loader sequence
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg       <= ST_DOWN;
      store_page      <= 7'h00;
      store_addr      <= 7'h00;
      store_read      <= 1'b0;
      hard_mode       <= 1'b0;
      config_invalid  <= 1'b0;
      serial_addr_lsb <= 2'h0;
      serial_enable   <= 1'b0;
      margin_enable   <= 1'b0;
      margin_offset   <= 3'h0;
      divider_sync    <= 1'b0;
      init_busy       <= 1'b1;
      for (k = 0; k < 124; k = k + 1)
        regs_reg[k] <= 8'h00;
    end else begin
      divider_sync <= 1'b0;
      case (state_reg)
        ST_DOWN: begin
          serial_enable <= 1'b0;
          init_busy     <= 1'b1;
          if (!powerdown_pin)
            state_reg <= ST_LATCH;
        end
        ST_LATCH: begin
          // mode pin caught once per power cycle
          hard_mode  <= config_source_select;
          store_addr <= 7'h00;
          if (config_source_select) begin
            store_page      <= {1'b0, gpio_level};
            serial_addr_lsb <= `HARD_ADDR_LSB;
            config_invalid  <= 1'b0;
            margin_enable   <= 1'b0;
            margin_offset   <= 3'h0;
            store_read      <= 1'b1;
            state_reg       <= ST_FETCH;
          end else begin
            // address low bits from pin 1
            serial_addr_lsb <= addr_lsb(gpio1_state);
            margin_enable   <= gpio_level[4];
            margin_offset   <= gpio5_level;
            config_invalid  <= (soft_sel == `SEL_INVALID);
            if (soft_sel < `SEL_DEFAULTS) begin
              store_page <= `EEPROM_BASE + {4'h0, soft_sel};
              store_read <= 1'b1;
              state_reg  <= ST_FETCH;
            end else begin
              state_reg <= ST_DEFAULT;
            end
          end
        end
        ST_FETCH: begin
          // byte zero is the page identifier
          if (store_addr != 7'h00)
            regs_reg[store_addr - 7'h01] <= store_data;
          if (store_addr == `REG_COUNT) begin
            state_reg     <= ST_RUN;
            serial_enable <= 1'b1;
            init_busy     <= 1'b0;
            divider_sync  <= hard_mode;
          end else begin
            store_read <= (store_addr != `REG_LAST);
            store_addr <= store_addr + 7'h01;
          end
        end
        ST_DEFAULT: begin
          regs_reg[store_addr] <= default_value(store_addr);
          if (store_addr == `REG_LAST) begin
            state_reg     <= ST_RUN;
            serial_enable <= 1'b1;
            init_busy     <= 1'b0;
          end else begin
            store_addr <= store_addr + 7'h01;
          end
        end
        ST_RUN: begin
          if (reg_wr_en && reg_addr < `REG_COUNT)
            regs_reg[reg_addr] <= reg_wdata;
          divider_sync <= ~hard_mode & ~output_sync_low;
        end
        default: state_reg <= ST_DOWN;
      endcase
      if (powerdown_pin) begin
        state_reg  <= ST_DOWN;
        store_read <= 1'b0;
      end
    end
  end

  // ==========================================================
  // field decode
  reg [7:0]  en_next, pos_next, neg_next, low_next, byp_next, cfg;
  reg [87:0] total_next;
  reg [1:0]  mux;
  reg        valid, muted, drive, run;
  reg [11:0] int_f;
  reg [21:0] num_f, den_f;
  reg [23:0] int_next;
  reg [43:0] num_next, den_next;
  reg [7:0]  ref_next, post_next;
  reg [11:0] in_next;
  reg [3:0]  dbl_next;
  integer    i, b;

  always @* begin
    en_next    = 8'h00;
    pos_next   = 8'h00;
    neg_next   = 8'h00;
    low_next   = 8'h00;
    byp_next   = 8'h00;
    total_next = 88'h0;
    int_next   = 24'h0;
    num_next   = 44'h0;
    den_next   = 44'h0;
    ref_next   = 8'h00;
    in_next    = 12'h000;
    dbl_next   = 4'h0;
    post_next  = 8'h00;
    cfg        = 8'h00;
    mux        = 2'h0;
    valid      = 1'b0;
    muted      = 1'b0;
    drive      = 1'b0;
    int_f      = 12'h000;
    num_f      = 22'h0;
    den_f      = 22'h0;
    b          = 0;
    run        = (state_reg == ST_RUN);
    for (i = 0; i < 8; i = i + 1) begin
      cfg   = regs_reg[`OFS_CH_CFG + i];
      mux   = cfg[`CFG_MUX_LSB +: 2];
      valid = mux[1] ? ref_present[mux[0]] : pll_locked[mux[0]];
      muted = ~valid & cfg[`CFG_MUTE_EN];
      drive = muted & (cfg[`CFG_MUTE_LSB +: 2] == `MUTE_LVL_DRIVE);
      en_next[i]  = run & ~muted;
      pos_next[i] = run & drive & ~cfg[`CFG_CMOS];
      neg_next[i] = run & drive & ~cfg[`CFG_CMOS];
      low_next[i] = run & drive & cfg[`CFG_CMOS];
      byp_next[i] = mux[1];
      b = `OFS_PLL_BASE + `PLL_STRIDE * mux[0] + `PLL_DIVCFG;
      total_next[i*11 +: 11] = mux[1] ? 11'h001 :
        total_divide(post_ratio(regs_reg[b][`POST_LSB +: 3]), regs_reg[`OFS_CH_DIV + i]);
    end
    for (i = 0; i < 2; i = i + 1) begin
      b     = `OFS_PLL_BASE + `PLL_STRIDE * i;
      int_f = {regs_reg[b + `PLL_INT_HI][3:0], regs_reg[b + `PLL_INT_LO]};
      num_f = {regs_reg[b + `PLL_NUM + 2][5:0], regs_reg[b + `PLL_NUM + 1], regs_reg[b + `PLL_NUM]};
      den_f = {regs_reg[b + `PLL_DEN + 2][5:0], regs_reg[b + `PLL_DEN + 1], regs_reg[b + `PLL_DEN]};
      int_next[i*12 +: 12] = (int_f == 12'h000) ? 12'h001 : int_f;
      num_next[i*22 +: 22] = num_f;
      den_next[i*22 +: 22] = (den_f == 22'h0) ? 22'h1 : den_f;
      cfg = regs_reg[b + `PLL_REFCFG];
      ref_next[i*4 +: 4] = cfg[`REF_SECONDARY] ? 4'h1 : {1'b0, cfg[`REF_DIV_LSB +: 3]} + 4'h1;
      dbl_next[i*2 +: 2] = cfg[`REF_DOUBLER] ? 2'h2 : 2'h1;
      cfg = regs_reg[b + `PLL_DIVCFG];
      in_next[i*6 +: 6]  = {1'b0, cfg[`IN_DIV_LSB +: 5]} + 6'h01;
      post_next[i*4 +: 4] = post_ratio(cfg[`POST_LSB +: 3]);
    end
  end

  // ==========================================================
  // registered outputs
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_enable        <= 8'h00;
      pos_node_high     <= 8'h00;
      neg_node_low      <= 8'h00;
      cmos_force_low    <= 8'h00;
      chan_bypass       <= 8'h00;
      chan_total_divide <= 88'h0;
      status_clock_mode <= 2'h0;
      status_divide     <= 16'h0000;
      status_slew       <= 4'h0;
      pll_int           <= 24'h0;
      pll_num           <= 44'h0;
      pll_den           <= 44'h0;
      pll_ref_div       <= 8'h00;
      pll_in_div        <= 12'h000;
      pll_doubler       <= 4'h0;
      pll_post          <= 8'h00;
      reg_rdata         <= 8'h00;
      page_id           <= 8'h00;
    end else begin
      out_enable        <= en_next;
      pos_node_high     <= pos_next;
      neg_node_low      <= neg_next;
      cmos_force_low    <= low_next;
      chan_bypass       <= byp_next;
      chan_total_divide <= total_next;
      // status pin use, divider, edge rate
      status_clock_mode <= regs_reg[`OFS_STATUS_CFG][`ST_MODE_LSB +: 2];
      status_slew       <= regs_reg[`OFS_STATUS_CFG][`ST_SLEW_LSB +: 4];
      status_divide     <= {regs_reg[`OFS_STATUS_DIV + 7'h01], regs_reg[`OFS_STATUS_DIV]};
      pll_int           <= int_next;
      pll_num           <= num_next;
      pll_den           <= den_next;
      pll_ref_div       <= ref_next;
      pll_in_div        <= in_next;
      pll_doubler       <= dbl_next;
      pll_post          <= post_next;
      reg_rdata         <= (reg_addr < `REG_COUNT) ? regs_reg[reg_addr] : 8'h00;
      page_id           <= regs_reg[`OFS_PAGE_ID];
    end
  end

endmodule // pin_strap_config_page_loader

//--- strap_loader_checker_assertions.sv
`timescale 1ns/100ps
module strap_loader_checker (
  // clock and reset
  input wire       clock,
  input wire       rst_n,
  // pins
  input wire       powerdown_pin,
  input wire [5:0] gpio_level,
  // state
  input wire       hard_mode,
  input wire       init_busy,
  input wire       serial_enable,
  input wire [1:0] serial_addr_lsb,
  input wire       divider_sync,
  // channels
  input wire [7:0] out_enable,
  input wire [7:0] pos_node_high,
  input wire [7:0] neg_node_low,
  input wire [7:0] cmos_force_low
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // checks
  a_busy_no_out: assert property (init_busy |-> out_enable == 8'h00)
    else $error("outputs enabled while initialising");
  a_pd_off: assert property (powerdown_pin [*2] |=> out_enable == 8'h00 && !serial_enable)
    else $error("outputs active in power-down");
  a_hard_addr: assert property (hard_mode && serial_enable |-> serial_addr_lsb == 2'h0)
    else $error("hard mode address bits not zero");
  a_run_serial: assert property ($fell(init_busy) |-> serial_enable)
    else $error("serial port off after load");
  a_sync_cause: assert property (hard_mode && $fell(init_busy) |-> divider_sync)
    else $error("no divider sync after load");
  a_sync_pulse: assert property (hard_mode && divider_sync |=> !divider_sync)
    else $error("divider sync longer than one cycle");
  a_soft_sync: assert property (!hard_mode && !init_busy && $past(!init_busy) && !powerdown_pin
    && !$past(powerdown_pin) |-> divider_sync == !$past(gpio_level[0]))
    else $error("sync does not follow pin 0");
  a_mode_held: assert property (!init_busy && !powerdown_pin |-> $stable(hard_mode))
    else $error("mode changed while running");
  a_diff_mute: assert property ((pos_node_high ^ neg_node_low) == 8'h00
    && (pos_node_high & out_enable) == 8'h00)
    else $error("differential mute drive wrong");
  a_cmos_mute: assert property ((cmos_force_low & (out_enable | pos_node_high)) == 8'h00)
    else $error("cmos mute on enabled channel");
endmodule // strap_loader_checker

bind pin_strap_config_page_loader strap_loader_checker u_chk (
  .clock(clock), .rst_n(rst_n), .powerdown_pin(powerdown_pin), .gpio_level(gpio_level),
  .hard_mode(hard_mode), .init_busy(init_busy), .serial_enable(serial_enable),
  .serial_addr_lsb(serial_addr_lsb), .divider_sync(divider_sync), .out_enable(out_enable),
  .pos_node_high(pos_node_high), .neg_node_low(neg_node_low), .cmos_force_low(cmos_force_low));

//--- page_store_model.sv
`timescale 1ns/100ps
module page_store_model (
  // clock
  input wire       clock,
  // read port
  input wire [6:0] store_page,
  input wire [6:0] store_addr,
  input wire       store_read,
  output reg [7:0] store_data
);
  // ==========================================
  // page contents
  function automatic [7:0] byte_of(input [6:0] p, input [6:0] a);
    if (a == 7'h00) byte_of = {1'b1, p};
    else if (a < 7'h09) byte_of = {1'b0, a};
    else if (a < 7'h11) byte_of = a[0] ? 8'h3C : 8'h1C;
    else if (a == 7'h1D) byte_of = 8'h60;
    else byte_of = 8'h00;
  endfunction
  initial store_data = 8'h00;
  // one byte per address, one cycle latency
  always @(posedge clock) begin
    if (store_read) begin
      store_data <= byte_of(store_page, store_addr);
    end else begin
      store_data <= ~store_data;
    end
  end
endmodule // page_store_model

//--- tb_pin_strap_config_page_loader.sv
`timescale 1ns/100ps
`include "strap_loader_map.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
  $display("Error at %0t: got %0h expected %0h", $time, (a), (b)); end end
module tb_pin_strap_config_page_loader;
  logic clock, rst_n, config_source_select, powerdown_pin, reg_wr_en, store_read;
  logic [5:0] gpio_level;
  logic [1:0] gpio1_state, gpio2_state, gpio3_state, pll_locked, ref_present;
  logic [2:0] gpio5_level;
  logic [6:0] store_page, store_addr, reg_addr;
  logic [7:0] store_data, reg_wdata, reg_rdata, page_id, pll_ref_div, pll_post;
  logic serial_enable, hard_mode, config_invalid, init_busy, divider_sync, margin_enable;
  logic [1:0] serial_addr_lsb, status_clock_mode;
  logic [2:0] margin_offset;
  logic [7:0] out_enable, pos_node_high, neg_node_low, cmos_force_low, chan_bypass;
  logic [87:0] chan_total_divide;
  logic [15:0] status_divide;
  logic [3:0] status_slew, pll_doubler;
  logic [23:0] pll_int;
  logic [43:0] pll_num, pll_den;
  logic [11:0] pll_in_div;
  int failures, num_checks, cycles;
  pin_strap_config_page_loader DUT (.clock(clock), .rst_n(rst_n),
    .config_source_select(config_source_select), .powerdown_pin(powerdown_pin),
    .gpio_level(gpio_level), .gpio1_state(gpio1_state), .gpio2_state(gpio2_state),
    .gpio3_state(gpio3_state), .gpio5_level(gpio5_level), .pll_locked(pll_locked),
    .ref_present(ref_present), .store_page(store_page), .store_addr(store_addr),
    .store_read(store_read), .store_data(store_data), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .serial_enable(serial_enable),
    .serial_addr_lsb(serial_addr_lsb), .hard_mode(hard_mode), .config_invalid(config_invalid),
    .init_busy(init_busy), .page_id(page_id), .divider_sync(divider_sync),
    .margin_enable(margin_enable), .margin_offset(margin_offset), .out_enable(out_enable),
    .pos_node_high(pos_node_high), .neg_node_low(neg_node_low), .cmos_force_low(cmos_force_low),
    .chan_bypass(chan_bypass), .chan_total_divide(chan_total_divide),
    .status_clock_mode(status_clock_mode), .status_divide(status_divide),
    .status_slew(status_slew), .pll_int(pll_int), .pll_num(pll_num), .pll_den(pll_den),
    .pll_ref_div(pll_ref_div), .pll_in_div(pll_in_div), .pll_doubler(pll_doubler),
    .pll_post(pll_post));
  page_store_model u_store (.clock(clock), .store_page(store_page), .store_addr(store_addr),
    .store_read(store_read), .store_data(store_data));
  // ==========================================
  // helpers
  task cyc(int n); repeat (n) @(negedge clock); endtask
  task wait_run();
    int i;
    for (i = 0; i < 400 && init_busy !== 1'b0; i++) cyc(1);
    `CHK(init_busy, 1'b0)
    `CHK(divider_sync, config_source_select)
    cyc(2);
    `CHK(divider_sync, 1'b0)
  endtask
  // power is cycled only between host writes
  task power_cycle();
    powerdown_pin = 1'b1;
    cyc(3);
    `CHK(out_enable, 8'h00)
    `CHK(init_busy, 1'b1)
    powerdown_pin = 1'b0;
    wait_run();
  endtask
  task wr(logic [6:0] a, logic [7:0] d);
    reg_wr_en = 1'b1; reg_addr = a; reg_wdata = d;
    cyc(1);
    reg_wr_en = 1'b0;
    cyc(2);
  endtask
  task wait_cycles_end();
    `CHK(1'b0, 1'b1)
  endtask
  task wrap_up();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task t_hard();
    power_cycle();
    `CHK(hard_mode, 1'b1)
    `CHK(page_id, 8'hAA)
    `CHK(serial_enable, 1'b1)
    `CHK(serial_addr_lsb, `HARD_ADDR_LSB)
    `CHK(chan_total_divide[10:0], 11'd6)
    `CHK(chan_total_divide[87:77], 11'd27)
    `CHK(pll_post[3:0], 4'd3)
    `CHK(out_enable, 8'hFF)
    `CHK(pll_int[23:12], 12'h001)
    `CHK(pll_den[21:0], 22'h1)
    `CHK(pll_den[43:22], 22'h1)
    `CHK(pll_ref_div[7:4], 4'h1)
    `CHK(pll_in_div[11:6], 6'h01)
    `CHK(pll_doubler[3:2], 2'h1)
  endtask
  task t_mute();
    pll_locked = 2'b10;
    cyc(3);
    `CHK(out_enable, 8'h00)
    `CHK(cmos_force_low, 8'h55)
    `CHK(pos_node_high, 8'hAA)
    `CHK(neg_node_low, 8'hAA)
    pll_locked = 2'b11;
    cyc(3);
    `CHK(out_enable, 8'hFF)
  endtask
  task t_host();
    wr(7'h01, 8'hFF);
    `CHK(chan_total_divide[10:0], 11'd768)
    wr(7'h09, 8'h02);
    `CHK(chan_bypass[0], 1'b1)
    `CHK(chan_total_divide[10:0], 11'd1)
    wr(7'h0A, 8'h1F);
    ref_present = 2'b01;
    cyc(3);
    `CHK(chan_bypass[1], 1'b1)
    `CHK(out_enable[1], 1'b0)
    `CHK(pos_node_high[1], 1'b1)
    `CHK(neg_node_low[1], 1'b1)
    ref_present = 2'b11;
    wr(7'h1D, 8'h1F);
    `CHK(pll_post[3:0], 4'd2)
    `CHK(pll_in_div[5:0], 6'd32)
    wr(7'h1C, 8'h0A);
    `CHK(pll_ref_div[3:0], 4'd3)
    `CHK(pll_doubler[1:0], 2'd2)
    wr(7'h1C, 8'h1A);
    `CHK(pll_ref_div[3:0], 4'd1)
    wr(7'h16, 8'h07);
    `CHK(pll_num[21:0], 22'h7)
    wr(7'h11, 8'h29);
    `CHK(status_clock_mode, 2'b01)
    `CHK(status_slew, 4'hA)
    wr(7'h12, 8'h34);
    wr(7'h13, 8'h12);
    `CHK(status_divide, 16'h1234)
    wr(7'h14, 8'hFF);
    wr(7'h15, 8'h0F);
    `CHK(pll_int[11:0], 12'hFFF)
    wr(7'h7B, 8'h5A);
    `CHK(reg_rdata, 8'h5A)
    wr(7'h7C, 8'h55);
    `CHK(reg_rdata, 8'h00)
  endtask
  task t_soft();
    logic [3:0] cd [10];
    logic [7:0] id [10];
    logic [9:0] inv;
    int k;
    cd = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hA, 4'h5, 4'h6, 4'h9, 4'hF};
    id = '{8'hC0, 8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hC5, 8'h00, 8'h00, 8'h00, 8'h00};
    inv = 10'b0110000000;
    config_source_select = 1'b0; gpio_level = 6'h11; gpio5_level = 3'h5;
    for (k = 0; k < 10; k++) begin
      {gpio3_state, gpio2_state} = cd[k];
      gpio1_state = 2'(k % 3);
      power_cycle();
      `CHK(page_id, id[k])
      `CHK(config_invalid, inv[k])
      `CHK(chan_total_divide[10:0], (k > 5) ? 11'd8 : 11'd6)
      `CHK(serial_addr_lsb, (k % 3 == 2) ? `ADDR_SUP : 2'(k % 3))
    end
    `CHK(margin_enable, 1'b1)
    `CHK(margin_offset, 3'h5)
    gpio_level = 6'h10;
    cyc(3);
    `CHK(divider_sync, 1'b1)
    config_source_select = 1'b1;
    cyc(3);
    `CHK(hard_mode, 1'b0)
    gpio_level = 6'h2A;
    power_cycle();
    `CHK(hard_mode, 1'b1)
  endtask
  // ==========================================
  // clock, timeout, main
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      wait_cycles_end();
      wrap_up();
    end
  end
  initial begin
    rst_n = 1'b0; config_source_select = 1'b1; powerdown_pin = 1'b0; gpio_level = 6'h2A;
    gpio1_state = 2'h0; gpio2_state = 2'h0; gpio3_state = 2'h0; gpio5_level = 3'h0;
    pll_locked = 2'b11; ref_present = 2'b11; reg_wr_en = 1'b0; reg_addr = 7'h00;
    reg_wdata = 8'h00;
    cyc(12);
    rst_n = 1'b1;
    wait_run();
    t_hard();
    t_mute();
    t_host();
    t_soft();
    wrap_up();
  end
endmodule // tb_pin_strap_config_page_loader
